// ### verilog/pmr_regs.sv
`timescale 1ns/1ps
`include "pmr_defs.svh"
module pmr_regs #(
	// arbitrary module name code; top bit set marks an isolated module
	parameter logic [5:0] MODULE_NAME_CODE = 6'h21
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire pmr_pkg::pmr_cmd_t cmdIn,
	input wire logic pecError,
	input wire pmr_pkg::pmr_evt_t evtIn,
	input wire pmr_pkg::pmr_telem_t telemIn,
	output pmr_pkg::pmr_rsp_t rspOut,
	output pmr_pkg::pmr_cal_t calOut,
	output logic writeProtectEnable
);

	// codes that answer a read
	function automatic logic isReadable(input logic [7:0] code);
		case (code)
			`PMR_CODE_SUMMARY, `PMR_CODE_IOUT_STAT, `PMR_CODE_INPUT_STAT,
			`PMR_CODE_TEMP_STAT, `PMR_CODE_COMM_STAT, `PMR_CODE_READ_VIN,
			`PMR_CODE_READ_VOUT, `PMR_CODE_READ_IOUT, `PMR_CODE_READ_TEMP,
			`PMR_CODE_REVISION, `PMR_CODE_DEV_TYPE, `PMR_CODE_VOUT_GAIN,
			`PMR_CODE_VOUT_OFS, `PMR_CODE_VIN_GAIN, `PMR_CODE_VIN_OFS,
			`PMR_CODE_IOUT_GAIN, `PMR_CODE_IOUT_OFS: isReadable = 1'b1;
			default: isReadable = 1'b0;
		endcase
	endfunction

	// the six calibration words
	function automatic logic isCal(input logic [7:0] code);
		case (code)
			`PMR_CODE_VOUT_GAIN, `PMR_CODE_VOUT_OFS, `PMR_CODE_VIN_GAIN,
			`PMR_CODE_VIN_OFS, `PMR_CODE_IOUT_GAIN, `PMR_CODE_IOUT_OFS: isCal = 1'b1;
			default: isCal = 1'b0;
		endcase
	endfunction

	// codes that accept a write
	function automatic logic isWritable(input logic [7:0] code);
		case (code)
			`PMR_CODE_CLEAR_ALL, `PMR_CODE_IOUT_STAT, `PMR_CODE_INPUT_STAT,
			`PMR_CODE_TEMP_STAT, `PMR_CODE_COMM_STAT,
			`PMR_CODE_DEV_TYPE: isWritable = 1'b1;
			default: isWritable = isCal(code);
		endcase
	endfunction

	// range and exponent check of a calibration value
	function automatic logic calValueOk(input logic [7:0] code, input logic [15:0] val);
		case (code)
			`PMR_CODE_VOUT_GAIN, `PMR_CODE_VIN_GAIN,
			`PMR_CODE_IOUT_GAIN: calValueOk = (val >= `PMR_GAIN_MIN) && (val <= `PMR_GAIN_MAX);
			`PMR_CODE_VIN_OFS: calValueOk = (val[15:11] == `PMR_EXP_VIN_OFS);
			`PMR_CODE_IOUT_OFS: calValueOk = (val[15:11] == `PMR_EXP_IOUT_OFS);
			default: calValueOk = 1'b1;
		endcase
	endfunction

	logic isWr;
	logic isRd;
	logic badCmd;
	logic calHit;
	logic calGood;
	logic calLoad;
	logic badData;
	logic clearAll;
	logic [7:0] ioutStat;
	logic [7:0] inputStat;
	logic [7:0] tempStat;
	logic [7:0] commStat;
	logic [7:0] ioutSet;
	logic [7:0] inputSet;
	logic [7:0] tempSet;
	logic [7:0] commSet;
	logic [7:0] ioutClr;
	logic [7:0] inputClr;
	logic [7:0] tempClr;
	logic [7:0] commClr;
	logic [15:0] summary;
	logic [15:0] devType;
	logic [15:0] readData;
	logic writeProtect_r;
	pmr_pkg::pmr_cal_t cal_r;
	pmr_pkg::pmr_rsp_t rsp_r;

	// transaction decode
	assign isWr = cmdIn.valid && cmdIn.write;
	assign isRd = cmdIn.valid && !cmdIn.write;
	assign badCmd = (isRd && !isReadable(cmdIn.code)) || (isWr && !isWritable(cmdIn.code));
	assign clearAll = isWr && (cmdIn.code == `PMR_CODE_CLEAR_ALL);
	// [RULE17] protect gates calibration
	assign calHit = isWr && isCal(cmdIn.code) && !writeProtect_r;
	// [RULE13] gain range check
	assign calGood = calValueOk(cmdIn.code, cmdIn.data);
	assign calLoad = calHit && calGood;
	// [RULE20] rejected value flags
	assign badData = calHit && !calGood;

	// [RULE1] output-current events
	assign ioutSet = {evtIn.ocFault, 1'b0, evtIn.ocWarn, 5'h00};
	// [RULE2] input events
	assign inputSet = {evtIn.vinOvFault, 2'h0, evtIn.vinUvFault, evtIn.unitOffLowIn, 3'h0};
	// [RULE3] temperature events
	assign tempSet = {evtIn.otFault, evtIn.otWarn, 6'h00};
	// [RULE4] communication events
	assign commSet = {badCmd, badData, pecError, 5'h00};

	// [RULE5] reset by writing ones, or clear all
	assign ioutClr = clearAll ? 8'hff : ((isWr && cmdIn.code == `PMR_CODE_IOUT_STAT) ?
		cmdIn.data[7:0] : 8'h00);
	assign inputClr = clearAll ? 8'hff : ((isWr && cmdIn.code == `PMR_CODE_INPUT_STAT) ?
		cmdIn.data[7:0] : 8'h00);
	assign tempClr = clearAll ? 8'hff : ((isWr && cmdIn.code == `PMR_CODE_TEMP_STAT) ?
		cmdIn.data[7:0] : 8'h00);
	assign commClr = clearAll ? 8'hff : ((isWr && cmdIn.code == `PMR_CODE_COMM_STAT) ?
		cmdIn.data[7:0] : 8'h00);

	// [RULE19] masks keep unsupported bits at zero
	pmr_flag_bank #(.SUPPORTED(`PMR_MASK_IOUT)) u_iout (
		.clk(clk),
		.sys_rst(sys_rst),
		.setIn(ioutSet),
		.clrIn(ioutClr),
		.flags(ioutStat)
	);
	pmr_flag_bank #(.SUPPORTED(`PMR_MASK_INPUT)) u_input (
		.clk(clk),
		.sys_rst(sys_rst),
		.setIn(inputSet),
		.clrIn(inputClr),
		.flags(inputStat)
	);
	pmr_flag_bank #(.SUPPORTED(`PMR_MASK_TEMP)) u_temp (
		.clk(clk),
		.sys_rst(sys_rst),
		.setIn(tempSet),
		.clrIn(tempClr),
		.flags(tempStat)
	);
	pmr_flag_bank #(.SUPPORTED(`PMR_MASK_COMM)) u_comm (
		.clk(clk),
		.sys_rst(sys_rst),
		.setIn(commSet),
		.clrIn(commClr),
		.flags(commStat)
	);

	// [RULE18] summary mirrors detail
	always_comb begin
		summary = 16'h0000;
		summary[`PMR_SUM_IOUT] = |ioutStat;
		summary[`PMR_SUM_INPUT] = |inputStat;
		summary[`PMR_SUM_TEMP] = |tempStat;
		summary[`PMR_SUM_COMM] = |commStat;
	end

	// [RULE9] device-type layout
	// [RULE11] isolated name code
	assign devType = {8'h00, MODULE_NAME_CODE, writeProtect_r, 1'b0};

	// protect bit stays writable even while set, otherwise it could never be released
	// [RULE10] protect bit storage
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			writeProtect_r <= `PMR_WPE_RST;
		end else if (isWr && cmdIn.code == `PMR_CODE_DEV_TYPE) begin
			writeProtect_r <= cmdIn.data[`PMR_BIT_WPE];
		end
	end

	// calibration words; reset loads the default values
	// [RULE12] gain defaults
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cal_r.voutGain <= `PMR_GAIN_RST;
			cal_r.voutOfs <= `PMR_VOUT_OFS_RST;
			cal_r.vinGain <= `PMR_GAIN_RST;
			cal_r.vinOfs <= `PMR_VIN_OFS_RST;
			cal_r.ioutGain <= `PMR_GAIN_RST;
			cal_r.ioutOfs <= `PMR_IOUT_OFS_RST;
		end else if (calLoad) begin
			case (cmdIn.code)
				`PMR_CODE_VOUT_GAIN: cal_r.voutGain <= cmdIn.data;
				// [RULE14] signed mantissa, fixed exponent
				`PMR_CODE_VOUT_OFS: cal_r.voutOfs <= cmdIn.data;
				`PMR_CODE_VIN_GAIN: cal_r.vinGain <= cmdIn.data;
				// [RULE15] exponent checked before
				`PMR_CODE_VIN_OFS: cal_r.vinOfs <= cmdIn.data;
				// [RULE16] current trim words
				`PMR_CODE_IOUT_GAIN: cal_r.ioutGain <= cmdIn.data;
				`PMR_CODE_IOUT_OFS: cal_r.ioutOfs <= cmdIn.data;
				default: cal_r.ioutOfs <= cal_r.ioutOfs;
			endcase
		end
	end

	// read mux; status bytes sit in the low byte
	always_comb begin
		readData = 16'h0000;
		case (cmdIn.code)
			`PMR_CODE_SUMMARY: readData = summary;
			`PMR_CODE_IOUT_STAT: readData = {8'h00, ioutStat};
			`PMR_CODE_INPUT_STAT: readData = {8'h00, inputStat};
			`PMR_CODE_TEMP_STAT: readData = {8'h00, tempStat};
			`PMR_CODE_COMM_STAT: readData = {8'h00, commStat};
			// [RULE6] live telemetry
			`PMR_CODE_READ_VIN: readData = telemIn.vin;
			`PMR_CODE_READ_VOUT: readData = telemIn.vout;
			`PMR_CODE_READ_IOUT: readData = telemIn.iout;
			`PMR_CODE_READ_TEMP: readData = telemIn.temp;
			// [RULE7] revision fields
			// [RULE8] reports 1.2
			`PMR_CODE_REVISION: readData = {8'h00, `PMR_REV_PART1, 1'b0, `PMR_REV_PART2};
			`PMR_CODE_DEV_TYPE: readData = devType;
			`PMR_CODE_VOUT_GAIN: readData = cal_r.voutGain;
			`PMR_CODE_VOUT_OFS: readData = cal_r.voutOfs;
			`PMR_CODE_VIN_GAIN: readData = cal_r.vinGain;
			`PMR_CODE_VIN_OFS: readData = cal_r.vinOfs;
			`PMR_CODE_IOUT_GAIN: readData = cal_r.ioutGain;
			`PMR_CODE_IOUT_OFS: readData = cal_r.ioutOfs;
			default: readData = 16'h0000;
		endcase
	end

	// answer one cycle after the read; unknown codes answer zero so the frame layer never hangs
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rsp_r <= '0;
		end else begin
			rsp_r.valid <= isRd;
			rsp_r.data <= isRd ? readData : rsp_r.data;
		end
	end

	assign rspOut = rsp_r;
	assign calOut = cal_r;
	assign writeProtectEnable = writeProtect_r;

	// checks
	a_gain_range: assert property (@(posedge clk) disable iff (sys_rst) // [RULE13]
		(calHit && cmdIn.code == `PMR_CODE_VOUT_GAIN &&
		(cmdIn.data < `PMR_GAIN_MIN || cmdIn.data > `PMR_GAIN_MAX))
		|=> $stable(cal_r.voutGain) && commStat[`PMR_BIT_BAD_DATA])
		else $error("out-of-range gain was accepted");

	a_protect_lock: assert property (@(posedge clk) disable iff (sys_rst) // [RULE17]
		(isWr && isCal(cmdIn.code) && writeProtect_r) |=> $stable(cal_r))
		else $error("calibration changed while protected");

	a_flag_sticky: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
		(ioutStat[7] && ioutClr == 8'h00) |=> ioutStat[7])
		else $error("latched fault dropped without reset");

	a_unsup_zero: assert property (@(posedge clk) disable iff (sys_rst) // [RULE19]
		(ioutStat & ~`PMR_MASK_IOUT) == 8'h00 && (inputStat & ~`PMR_MASK_INPUT) == 8'h00 &&
		(tempStat & ~`PMR_MASK_TEMP) == 8'h00 && (commStat & ~`PMR_MASK_COMM) == 8'h00)
		else $error("unsupported status bit set");

	a_rev_value: assert property (@(posedge clk) disable iff (sys_rst) // [RULE8]
		(isRd && cmdIn.code == `PMR_CODE_REVISION) |=> rspOut.valid && rspOut.data == 16'h0042)
		else $error("wrong revision byte");

	a_summary_mirror: assert property (@(posedge clk) disable iff (sys_rst) // [RULE18]
		(isRd && cmdIn.code == `PMR_CODE_SUMMARY) |=>
		rspOut.data[`PMR_SUM_IOUT] == |$past(ioutStat) &&
		rspOut.data[`PMR_SUM_COMM] == |$past(commStat))
		else $error("summary does not mirror detail");

	a_telem_live: assert property (@(posedge clk) disable iff (sys_rst) // [RULE6]
		(isRd && cmdIn.code == `PMR_CODE_READ_IOUT) |=> rspOut.data == $past(telemIn.iout))
		else $error("telemetry read not live");

	a_bad_command: assert property (@(posedge clk) disable iff (sys_rst) // [RULE4]
		(isRd && !isReadable(cmdIn.code)) |=> commStat[`PMR_BIT_BAD_CMD] ##1
		(commStat[`PMR_BIT_BAD_CMD] || $past(commClr[`PMR_BIT_BAD_CMD])))
		else $error("invalid command not flagged");

	a_dev_type: assert property (@(posedge clk) disable iff (sys_rst) // [RULE9]
		(isRd && cmdIn.code == `PMR_CODE_DEV_TYPE) |=>
		rspOut.data[15:8] == 8'h00 && rspOut.data[0] == 1'b0 && rspOut.data[7])
		else $error("device-type word layout wrong");

	a_ofs_exponent: assert property (@(posedge clk) disable iff (sys_rst) // [RULE15]
		cal_r.vinOfs[15:11] == `PMR_EXP_VIN_OFS && cal_r.ioutOfs[15:11] == `PMR_EXP_IOUT_OFS)
		else $error("offset word with wrong exponent stored");

	// each supported event raises its flag on the following edge
	a_oc_fault_set: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
		evtIn.ocFault |=> ioutStat[7])
		else $error("over-current fault not latched");

	a_oc_warn_set: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
		evtIn.ocWarn |=> ioutStat[5])
		else $error("over-current warning not latched");

	a_input_uv_set: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
		evtIn.vinUvFault |=> inputStat[4])
		else $error("input under-voltage not latched");

	a_temp_warn_set: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
		evtIn.otWarn |=> tempStat[6])
		else $error("temperature warning not latched");

	a_pec_flag_set: assert property (@(posedge clk) disable iff (sys_rst) // [RULE4]
		pecError |=> commStat[`PMR_BIT_PEC])
		else $error("checksum failure not latched");

	// a clear only takes when no new event lands in the same cycle
	a_status_clear: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
		(isWr && cmdIn.code == `PMR_CODE_TEMP_STAT && cmdIn.data[7] && !evtIn.otFault)
		|=> !tempStat[7])
		else $error("temperature fault not reset by write");

	a_clear_all: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
		(clearAll && !evtIn.ocFault && !evtIn.ocWarn) |=> ioutStat == 8'h00)
		else $error("clear-all left a current flag");

	// protect bit follows every type-word write, even while it is set
	a_protect_write: assert property (@(posedge clk) disable iff (sys_rst) // [RULE10]
		(isWr && cmdIn.code == `PMR_CODE_DEV_TYPE) |=>
		writeProtect_r == $past(cmdIn.data[`PMR_BIT_WPE]))
		else $error("protect bit not taken from write");

	// rejected gains leave the stored word alone
	a_vin_gain_range: assert property (@(posedge clk) disable iff (sys_rst) // [RULE13]
		(calHit && cmdIn.code == `PMR_CODE_VIN_GAIN &&
		(cmdIn.data < `PMR_GAIN_MIN || cmdIn.data > `PMR_GAIN_MAX))
		|=> $stable(cal_r.vinGain))
		else $error("out-of-range input gain was accepted");

	a_trim_load: assert property (@(posedge clk) disable iff (sys_rst) // [RULE16]
		(calLoad && cmdIn.code == `PMR_CODE_IOUT_GAIN) |=>
		cal_r.ioutGain == $past(cmdIn.data))
		else $error("current gain write lost");

	// a dropped value must leave a trace for the host
	a_bad_data_flag: assert property (@(posedge clk) disable iff (sys_rst) // [RULE20]
		badData |=> commStat[`PMR_BIT_BAD_DATA])
		else $error("rejected value not flagged");

	c_cal_write: cover property (@(posedge clk) disable iff (sys_rst) calLoad);
	c_rejected: cover property (@(posedge clk) disable iff (sys_rst) badData);
	c_locked: cover property (@(posedge clk) disable iff (sys_rst)
		isWr && isCal(cmdIn.code) && writeProtect_r);
	c_fault_clear: cover property (@(posedge clk) disable iff (sys_rst)
		ioutStat[7] ##1 !ioutStat[7]);

endmodule // pmr_regs

// ### verilog/pmr_defs.svh
// How it works
// [RULE1] output-current status at 0x7b: bit 7 over-current fault, bit 5 warning only
// [RULE2] input status at 0x7c: bit 7 over-voltage, bit 4 under-voltage, bit 3 unit off
// [RULE3] temperature status at 0x7d: bit 7 over-temperature fault, bit 6 warning
// [RULE4] comm status at 0x7e: bit 7 bad command, 6 bad data, 5 checksum failed
// [RULE5] all status bits readable and resettable; set flags stay latched until reset
// [RULE6] telemetry reads at 0x88, 0x8b, 0x8c, 0x8d return the present measurement
// [RULE7] revision byte at 0x98: part one in bits 7:5, part two in 3:0
// [RULE8] both revision fields report version 1.2: codes 010 and 0010
// [RULE9] device-type word at 0xd0: high byte reserved, name 7:2, protect bit 1
// [RULE10] protect bit one means calibration writes locked, zero means unlocked
// [RULE11] module name code has its top bit set for isolated modules
// [RULE12] output and input voltage gains at 0xd1 and 0xd3 default to 0x2000
// [RULE13] gain words accept only values from 0x1999 to 0x2666 inclusive
// [RULE14] output-voltage offset at 0xd2 is a signed mantissa, exponent fixed at -12
// [RULE15] input-voltage offset at 0xd4 must carry exponent -3
// [RULE16] current gain at 0xd6 and current offset at 0xd7, offset exponent -4
// [RULE17] all six calibration words keep their value while protection is active
// [RULE18] summary word bits 14, 13, 2, 1 mirror the four detailed status registers
// [RULE19] unsupported and reserved status bits always read zero and are never set
// [RULE20] out-of-range or wrong-exponent calibration writes are dropped and flag bad data; here the flag is set only while the protect bit is zero
// [RULE21] host clears the protect bit before calibrating and sets it again afterwards
`ifndef PMR_DEFS_SVH
`define PMR_DEFS_SVH

// command codes
`define PMR_CODE_CLEAR_ALL 8'h03
`define PMR_CODE_SUMMARY 8'h79
`define PMR_CODE_IOUT_STAT 8'h7b
`define PMR_CODE_INPUT_STAT 8'h7c
`define PMR_CODE_TEMP_STAT 8'h7d
`define PMR_CODE_COMM_STAT 8'h7e
`define PMR_CODE_READ_VIN 8'h88
`define PMR_CODE_READ_VOUT 8'h8b
`define PMR_CODE_READ_IOUT 8'h8c
`define PMR_CODE_READ_TEMP 8'h8d
`define PMR_CODE_REVISION 8'h98
`define PMR_CODE_DEV_TYPE 8'hd0
`define PMR_CODE_VOUT_GAIN 8'hd1
`define PMR_CODE_VOUT_OFS 8'hd2
`define PMR_CODE_VIN_GAIN 8'hd3
`define PMR_CODE_VIN_OFS 8'hd4
`define PMR_CODE_IOUT_GAIN 8'hd6
`define PMR_CODE_IOUT_OFS 8'hd7

// supported-bit masks of the status registers
`define PMR_MASK_IOUT 8'ha0
`define PMR_MASK_INPUT 8'h98
`define PMR_MASK_TEMP 8'hc0
`define PMR_MASK_COMM 8'he0

// field positions
`define PMR_BIT_BAD_CMD 7
`define PMR_BIT_BAD_DATA 6
`define PMR_BIT_PEC 5
`define PMR_BIT_WPE 1
`define PMR_SUM_IOUT 14
`define PMR_SUM_INPUT 13
`define PMR_SUM_TEMP 2
`define PMR_SUM_COMM 1

// revision byte: 1.2 for both parts, bit 4 unused
`define PMR_REV_PART1 3'h2
`define PMR_REV_PART2 4'h2

// calibration limits, exponents and reset values
`define PMR_GAIN_MIN 16'h1999
`define PMR_GAIN_MAX 16'h2666
`define PMR_EXP_VIN_OFS 5'h1d
`define PMR_EXP_IOUT_OFS 5'h1c
`define PMR_GAIN_RST 16'h2000
`define PMR_VOUT_OFS_RST 16'h0000
`define PMR_VIN_OFS_RST 16'he800
`define PMR_IOUT_OFS_RST 16'he000
`define PMR_WPE_RST 1'h1

`endif

// ### verilog/pmr_pkg.sv
package pmr_pkg;

	// one decoded bus transaction from the frame layer
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] code;
		logic [15:0] data;
	} pmr_cmd_t;

	// read answer
	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} pmr_rsp_t;

	// fault and warning events from the power stage
	typedef struct packed {
		logic ocFault;
		logic ocWarn;
		logic vinOvFault;
		logic vinUvFault;
		logic unitOffLowIn;
		logic otFault;
		logic otWarn;
	} pmr_evt_t;

	// present measurements
	typedef struct packed {
		logic [15:0] vin;
		logic [15:0] vout;
		logic [15:0] iout;
		logic [15:0] temp;
	} pmr_telem_t;

	// calibration words handed to the readback path
	typedef struct packed {
		logic [15:0] voutGain;
		logic [15:0] voutOfs;
		logic [15:0] vinGain;
		logic [15:0] vinOfs;
		logic [15:0] ioutGain;
		logic [15:0] ioutOfs;
	} pmr_cal_t;

endpackage

// ### verilog/pmr_flag_bank.sv
`timescale 1ns/1ps
// eight sticky flags; only bits in SUPPORTED can ever be set
module pmr_flag_bank #(
	parameter logic [7:0] SUPPORTED = 8'h00
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] setIn,
	input wire logic [7:0] clrIn,
	output logic [7:0] flags
);

	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_bit
			if (SUPPORTED[i]) begin : g_sup
				logic flag_r;
				// latch until reset; a set in the clear cycle wins
				always_ff @(posedge clk or posedge sys_rst) begin
					if (sys_rst) begin
						flag_r <= 1'b0;
					end else if (setIn[i]) begin
						flag_r <= 1'b1;
					end else if (clrIn[i]) begin
						flag_r <= 1'b0;
					end
				end
				assign flags[i] = flag_r;
			end else begin : g_uns
				// unsupported bits are tied off so nothing can set them
				assign flags[i] = 1'b0;
			end
		end
	endgenerate

endmodule // pmr_flag_bank

// ### verif/pmr_host_model.sv
`timescale 1ns/1ps
// bus-host stand-in: hands decoded transactions to the register bank one edge at a time
module pmr_host_model (
	input wire logic clk,
	output pmr_pkg::pmr_cmd_t cmdOut,
	input wire pmr_pkg::pmr_rsp_t rspIn
);
	initial begin
		cmdOut = '0;
	end

	// one slot per edge; idle slots carry junk so stale fields are never trusted
	task automatic put(input logic v, input logic w, input logic [7:0] c, input logic [15:0] d);
		@(posedge clk);
		if (v) begin
			cmdOut <= {v, w, c, d};
		end else begin
			cmdOut <= {1'b0, 25'($urandom)};
		end
	endtask

	// idle gaps let the host answer slowly as well as promptly
	task automatic idle(input int n);
		repeat (n) put(1'b0, 1'b0, 8'h00, 16'h0000);
	endtask

	// every write is followed by an idle slot so valid stays a single pulse;
	// return just past the taking edge so registered results are already settled
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		put(1'b1, 1'b1, c, d);
		put(1'b0, 1'b0, 8'h00, 16'h0000);
		#1;
	endtask

	// answer is registered at the edge that takes the read, so look just after it
	task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic v);
		put(1'b1, 1'b0, c, 16'h0000);
		put(1'b0, 1'b0, 8'h00, 16'h0000);
		#1;
		v = rspIn.valid;
		d = rspIn.data;
	endtask

	task automatic protect(input logic on);
		wr(8'hd0, {14'h0000, on, 1'b0});
	endtask
endmodule // pmr_host_model

// ### verif/pmbus_status_and_calibration_regs_tb.sv
`timescale 1ns/1ps
module pmbus_status_and_calibration_regs_tb;
	// arbitrary module name code, top bit set for an isolated module
	localparam logic [5:0] NAME = 6'h27;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic pecError = 1'b0;
	logic write_protect_enable;
	logic wpeExp;
	pmr_pkg::pmr_cmd_t cmd;
	pmr_pkg::pmr_evt_t evt = '0;
	pmr_pkg::pmr_telem_t telem = '0;
	pmr_pkg::pmr_rsp_t rsp;
	pmr_pkg::pmr_cal_t cal;
	logic [15:0] calExp [6];
	logic [31:0] s;
	logic [15:0] v;
	int err_count = 0;
	int samples_checked = 0;
	int cycles = 0;

	pmr_regs #(.MODULE_NAME_CODE(NAME)) i_pmr_regs (.clk(clk), .sys_rst(sys_rst), .cmdIn(cmd),
		.pecError(pecError), .evtIn(evt), .telemIn(telem), .rspOut(rsp), .calOut(cal),
		.writeProtectEnable(write_protect_enable));
	pmr_host_model i_pmr_host_model (.clk(clk), .cmdOut(cmd), .rspIn(rsp));

	always #2.5 clk = ~clk;

	// hang guard: the whole run needs under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			$display("mismatch at %0t: run did not finish", $time);
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rdx(input logic [7:0] c, input logic [15:0] exp);
		logic [15:0] d;
		logic vld;
		i_pmr_host_model.rd(c, d, vld);
		chk({15'h0000, vld}, 16'h0001);
		chk(d, exp);
	endtask

	// one-cycle event pulse from the power stage
	task automatic fire(input logic [6:0] e, input logic p);
		@(posedge clk);
		evt <= e;
		pecError <= p;
		@(posedge clk);
		evt <= '0;
		pecError <= 1'b0;
	endtask

	// flags packed as iout, input, temp bytes in the upper 24 bits
	function automatic logic [31:0] stat(input logic [6:0] e);
		return {e[6], 1'b0, e[5], 5'h00, e[4], 2'b00, e[3], e[2], 3'b000, e[1], e[0], 14'h0000};
	endfunction

	// calibration words sit at d1..d4 then d6, d7 (d5 is a gap)
	function automatic logic [7:0] code(input int i);
		return (i < 4) ? 8'(8'hd1 + i) : 8'(8'hd2 + i);
	endfunction

	function automatic logic okv(input int i, input logic [15:0] x);
		if (i == 3) return x[15:11] === 5'h1d;
		if (i == 5) return x[15:11] === 5'h1c;
		if (i == 1) return 1'b1;
		return x >= 16'h1999 && x <= 16'h2666;
	endfunction

	// write one word, then check storage, readback and the bad-data flag
	task automatic calw(input int i, input logic [15:0] x);
		logic acc;
		acc = okv(i, x);
		i_pmr_host_model.wr(code(i), x);
		if (!wpeExp && acc) calExp[i] = x;
		rdx(code(i), calExp[i]);
		chk(16'(cal >> (16 * (5 - i))), calExp[i]);
		rdx(8'h7e, (!wpeExp && !acc) ? 16'h0040 : 16'h0000);
		if (!wpeExp && !acc) i_pmr_host_model.wr(8'h7e, 16'h00ff);
	endtask

	task automatic rstchk();
		calExp = '{16'h2000, 16'h0000, 16'h2000, 16'he800, 16'h2000, 16'he000};
		wpeExp = 1'b1;
		for (int i = 0; i < 6; i++) begin
			rdx(code(i), calExp[i]);
			chk(16'(cal >> (16 * (5 - i))), calExp[i]);
		end
		chk({15'h0000, write_protect_enable}, 16'h0001);
		rdx(8'hd0, {8'h00, NAME, 2'b10});
		rdx(8'h98, 16'h0042);
	endtask

	initial begin
		void'($urandom(37));
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		rstchk();
		// status flags: each event alone, then all together, with pec on odd rounds
		for (int r = 0; r < 8; r++) begin
			fire((r < 7) ? 7'(1 << r) : 7'h7f, r[0]);
			i_pmr_host_model.idle($urandom_range(1, 20));
			s = stat((r < 7) ? 7'(1 << r) : 7'h7f);
			rdx(8'h7b, {8'h00, s[31:24]});
			rdx(8'h7c, {8'h00, s[23:16]});
			rdx(8'h7d, {8'h00, s[15:8]});
			rdx(8'h7e, {10'h000, r[0], 5'h00});
			rdx(8'h79, {1'b0, |s[31:24], |s[23:16], 10'h000, |s[15:8], r[0], 1'b0});
			if (r[1]) begin
				i_pmr_host_model.wr(8'h03, 16'h0000);
			end else begin
				for (int k = 0; k < 4; k++) i_pmr_host_model.wr(8'(8'h7b + k), 16'h00ff);
			end
			for (int k = 0; k < 4; k++) rdx(8'(8'h7b + k), 16'h0000);
		end
		// unknown read answers zero, write to read-only byte refused
		rdx(8'h55, 16'h0000);
		i_pmr_host_model.wr(8'h98, 16'h00ff);
		rdx(8'h7e, 16'h0080);
		rdx(8'h98, 16'h0042);
		i_pmr_host_model.wr(8'h7e, 16'h00ff);
		// telemetry follows the present measurement; let the new value land before it is read
		for (int r = 0; r < 3; r++) begin
			@(posedge clk);
			telem <= {$urandom, $urandom};
			@(posedge clk);
			rdx(8'h88, telem.vin);
			rdx(8'h8b, telem.vout);
			rdx(8'h8c, telem.iout);
			rdx(8'h8d, telem.temp);
		end
		// locked: writes do nothing and raise no flag
		calw(0, 16'h2100);
		calw(3, 16'he805);
		i_pmr_host_model.protect(1'b0);
		wpeExp = 1'b0;
		chk({15'h0000, write_protect_enable}, 16'h0000);
		// reserved bits of the type word ignore junk; only protect changes
		i_pmr_host_model.wr(8'hd0, 16'hfffd);
		rdx(8'hd0, {8'h00, NAME, 2'b00});
		calw(0, 16'h1999);
		calw(2, 16'h2666);
		calw(0, 16'h1998);
		calw(2, 16'h2667);
		calw(4, 16'h1999);
		calw(1, 16'hf123);
		calw(3, 16'he005);
		calw(5, 16'he800);
		// offset slots get right and wrong exponents in turn so both outcomes occur
		for (int k = 0; k < 30; k++) begin
			v = 16'($urandom);
			if (k % 3 != 0) v = 16'(16'h1999 + v % 16'h0cce);
			if (k % 6 == 3 || k % 6 == 5) v[15:11] = (k % 4 == 1) ? 5'h1d : 5'h1c;
			calw(k % 6, v);
			i_pmr_host_model.idle($urandom_range(0, 3));
		end
		i_pmr_host_model.protect(1'b1);
		wpeExp = 1'b1;
		chk({15'h0000, write_protect_enable}, 16'h0001);
		for (int i = 0; i < 6; i++) calw(i, 16'h2001);
		// second reset in mid-run restores the factory values
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rstchk();
		final_report();
	end
endmodule // pmbus_status_and_calibration_regs_tb
